// *** design/owsl_regs.svh ***
// constants of the single-wire programming link
`ifndef OWSL_REGS_SVH
`define OWSL_REGS_SVH
`define OWSL_CLK_NS 50
`define OWSL_BIT_MAX_NS 100000
`define OWSL_BIT_MAX_CYC (`OWSL_BIT_MAX_NS / `OWSL_CLK_NS)
`define OWSL_TMO_CYC (2 * `OWSL_BIT_MAX_CYC)
`define OWSL_MBIT_NS 20000
`define OWSL_MBIT_CYC (`OWSL_MBIT_NS / `OWSL_CLK_NS)
`define OWSL_FILT_NS 150
`define OWSL_FILT_CYC ((`OWSL_FILT_NS + `OWSL_CLK_NS - 1) / `OWSL_CLK_NS)
`define OWSL_STOP_PER 2
`define OWSL_CMD_BITS 9
`define OWSL_FRAME_BITS 27
`define OWSL_RX_BITS 18
`define OWSL_TX_BITS 19
`define OWSL_MTX_BITS 28
`define OWSL_CMD_DATA_BIT 7
`define OWSL_CMD_READ_BIT 6
`define OWSL_CMD_BLK_BIT 5
`define OWSL_ADDR_W 5
`define OWSL_CNT_W 16
`endif

// *** design/owsl_pkg.sv ***
// state types of both link ends
`default_nettype none
package owsl_pkg;
	typedef enum logic [2:0] {
		OWSL_S_IDLE = 3'h0,
		OWSL_S_RECV = 3'h1,
		OWSL_S_TAKE = 3'h2,
		OWSL_S_SEND = 3'h3,
		OWSL_S_WSTOP = 3'h4
	} owsl_sstate_type;
	typedef enum logic [2:0] {
		OWSL_M_IDLE = 3'h0,
		OWSL_M_SEND = 3'h1,
		OWSL_M_LISTEN = 3'h2,
		OWSL_M_TAKE = 3'h3,
		OWSL_M_STOP = 3'h4
	} owsl_mstate_type;
endpackage : owsl_pkg
`default_nettype wire

// *** design/owsl_if.sv ***
// the shared wire between master and slave
`default_nettype none
interface owsl_if;
	logic m_out;
	logic m_oe;
	logic s_out;
	logic s_oe;
	logic line;
	// a driven low wins, an undriven wire is pulled low
	assign line = (m_oe | s_oe) & ~(m_oe & ~m_out) & ~(s_oe & ~s_out);
	modport master (output m_out, output m_oe, input line);
	modport slave (output s_out, output s_oe, input line);
endinterface : owsl_if
`default_nettype wire

// *** design/owsl_deglitch.sv ***
// pin synchroniser with glitch suppression
`default_nettype none
`include "owsl_regs.svh"
module owsl_deglitch #(
	parameter int FILT_LEN = `OWSL_FILT_CYC
) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic pin_i,
	output logic level_o
);
	logic meta;
	logic sync;
	logic [7:0] run;

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta <= 1'b0;
			sync <= 1'b0;
		end else begin
			meta <= pin_i;
			sync <= meta;
		end
	end

	// level changes only after FILT_LEN stable samples
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			run <= 8'h00;
			level_o <= 1'b0;
		end else if (sync == level_o) begin
			run <= 8'h00;
		end else if (run >= 8'(FILT_LEN - 1)) begin
			run <= 8'h00;
			level_o <= sync;
		end else begin
			run <= run + 8'h01;
		end
	end
endmodule : owsl_deglitch
`default_nettype wire

// *** design/owsl_slave.sv ***
// slave end of the single-wire programming link
//
// Overview of operation
// R1 - START, command, optional word, STOP, idle
// R2 - words are 16 bits, MSB first
// R3 - every byte carries an even parity bit
// R4 - write: word follows command, then STOP
// R5 - read: master releases at 3/4 final bit
// R6 - slave takes over on fall, then sends
// R7 - trailing zero, released at 3/4 bit
// R8 - master takes over, then sends STOP
// R9 - action command: STOP right after command
// R10 - no rise for twice max period: idle
// R11 - four segments: first high, last low
// R12 - middle segments carry the data value
// R13 - bit period measured from rising edges
// R14 - data decoded from falling edge position
// R15 - one master, one slave, no selection
// R16 - input glitches suppressed before edge detect
// R17 - parity precedes byte; upper byte first
// R18 - command: class, read, block, five-bit address
// R19 - parity error discards the command
// R20 - proper STOP returns slave to idle
// R21 - one when high time exceeds half period
`default_nettype none
`include "owsl_regs.svh"
module owsl_slave #(
	parameter int FILT_LEN = `OWSL_FILT_CYC,
	parameter int TMO_CYC = `OWSL_TMO_CYC
) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	owsl_if.slave link,
	input wire logic [15:0] rd_data_i,
	output logic exec_o,
	output logic rd_req_o,
	output logic perr_o,
	output logic busy_o,
	output logic data_access_o,
	output logic read_access_o,
	output logic block_select_o,
	output logic [`OWSL_ADDR_W-1:0] addr_o,
	output logic [15:0] wdata_o
);
	localparam int CW = `OWSL_CNT_W;
	localparam int DB = `OWSL_CMD_DATA_BIT;
	localparam int RB = `OWSL_CMD_READ_BIT;

	owsl_pkg::owsl_sstate_type state;
	logic filt;
	logic filt_d;
	logic rise;
	logic fall;
	logic first;
	logic bit_val;
	logic stop_seen;
	logic timed_out;
	logic [CW-1:0] since_rise;
	logic [CW-1:0] high_cnt;
	logic [CW-1:0] period;
	logic [CW-1:0] q1;
	logic [CW-1:0] q3;
	logic [CW:0] stop_lim;
	logic [CW-1:0] cyc;
	logic [4:0] nbit;
	logic [4:0] tbit;
	logic [`OWSL_FRAME_BITS-1:0] rx;
	logic [`OWSL_TX_BITS-1:0] txd;
	logic [7:0] cmd_q;
	logic [7:0] cmd9;
	logic cmd9_ok;
	logic act_ok;
	logic wr_ok;
	logic wr_bad;
	logic next_out;
	logic next_oe;

	// ----------------------------------------------------------------
	// input path and edges
	// ----------------------------------------------------------------
	owsl_deglitch #(.FILT_LEN(FILT_LEN)) u_flt ( // see R16
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.pin_i(link.line),
		.level_o(filt)
	);

	assign rise = filt & ~filt_d;
	assign fall = ~filt & filt_d;

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			filt_d <= 1'b0;
			since_rise <= '0;
			high_cnt <= '0;
		end else begin
			filt_d <= filt;
			if (rise) begin
				since_rise <= '0;
				high_cnt <= CW'(1);
			end else begin
				if (~&since_rise) begin
					since_rise <= since_rise + CW'(1);
				end
				if (filt && ~&high_cnt) begin
					high_cnt <= high_cnt + CW'(1);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// regenerated bit clock
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			period <= '0;
		end else if (state == owsl_pkg::OWSL_S_IDLE) begin
			period <= '0;
		end else if (rise && state == owsl_pkg::OWSL_S_RECV) begin
			period <= since_rise + CW'(1); // see R13
		end
	end

	assign q1 = period >> 2;
	assign q3 = q1 + (q1 << 1);
	assign stop_lim = {1'b0, period} + {2'b00, period[CW-1:1]};
	assign bit_val = high_cnt > (period >> 1); // see R14, R21
	assign stop_seen = filt && period != '0 &&
		{1'b0, high_cnt} > stop_lim;
	assign timed_out = state != owsl_pkg::OWSL_S_IDLE &&
		since_rise > CW'(TMO_CYC); // see R10

	// ----------------------------------------------------------------
	// frame checks
	// ----------------------------------------------------------------
	assign cmd9 = {rx[6:0], bit_val};
	assign cmd9_ok = rx[7] == ^cmd9; // see R3
	assign act_ok = nbit == 5'(`OWSL_CMD_BITS) && !rx[DB] &&
		rx[8] == ^rx[7:0]; // see R9
	assign wr_bad = rx[26] != ^rx[25:18] || rx[17] != ^rx[16:9] ||
		rx[8] != ^rx[7:0]; // see R17
	assign wr_ok = nbit == 5'(`OWSL_FRAME_BITS) && rx[25] && !rx[24] &&
		!wr_bad; // see R4

	// ----------------------------------------------------------------
	// transaction sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= owsl_pkg::OWSL_S_IDLE;
			first <= 1'b0;
			nbit <= 5'h00;
			rx <= '0;
		end else if (timed_out) begin
			state <= owsl_pkg::OWSL_S_IDLE; // see R10
		end else begin
			case (state)
				owsl_pkg::OWSL_S_IDLE: begin
					if (rise) begin // see R1
						state <= owsl_pkg::OWSL_S_RECV;
						first <= 1'b1;
						nbit <= 5'h00;
					end
				end
				owsl_pkg::OWSL_S_RECV: begin
					if (stop_seen) begin
						state <= owsl_pkg::OWSL_S_IDLE; // see R20
					end else if (fall && first) begin
						first <= 1'b0;
					end else if (fall && nbit < 5'(`OWSL_FRAME_BITS)) begin
						rx <= {rx[`OWSL_FRAME_BITS-2:0], bit_val}; // see R2
						nbit <= nbit + 5'h01;
						if (nbit == 5'(`OWSL_CMD_BITS - 1) && cmd9[DB] &&
							cmd9[RB] && cmd9_ok) begin
							state <= owsl_pkg::OWSL_S_TAKE; // see R5, R6
						end
					end
				end
				owsl_pkg::OWSL_S_TAKE: begin
					if (cyc == period - CW'(1)) begin
						state <= owsl_pkg::OWSL_S_SEND;
					end
				end
				owsl_pkg::OWSL_S_SEND: begin
					if (tbit == 5'(`OWSL_TX_BITS - 1) && cyc == q3) begin
						state <= owsl_pkg::OWSL_S_WSTOP; // see R7
					end
				end
				owsl_pkg::OWSL_S_WSTOP: begin
					if (stop_seen) begin
						state <= owsl_pkg::OWSL_S_IDLE; // see R8, R20
					end
				end
				default: begin
					state <= owsl_pkg::OWSL_S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// user-side results
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			exec_o <= 1'b0;
			rd_req_o <= 1'b0;
			perr_o <= 1'b0;
			cmd_q <= 8'h00;
			wdata_o <= 16'h0000;
		end else begin
			exec_o <= 1'b0;
			rd_req_o <= 1'b0;
			perr_o <= 1'b0;
			if (timed_out) begin
				exec_o <= 1'b0;
			end else if (state == owsl_pkg::OWSL_S_RECV && stop_seen) begin
				if (act_ok) begin
					exec_o <= 1'b1;
					cmd_q <= rx[7:0];
				end else if (wr_ok) begin
					exec_o <= 1'b1;
					cmd_q <= rx[25:18];
					wdata_o <= {rx[16:9], rx[7:0]};
				end else if ((nbit == 5'(`OWSL_CMD_BITS) &&
					rx[8] != ^rx[7:0]) ||
					(nbit == 5'(`OWSL_FRAME_BITS) && wr_bad)) begin
					perr_o <= 1'b1; // see R19
				end
			end else if (state == owsl_pkg::OWSL_S_RECV && fall && !first &&
				nbit == 5'(`OWSL_CMD_BITS - 1)) begin
				if (!cmd9_ok) begin
					perr_o <= 1'b1; // see R19
				end else if (cmd9[DB] && cmd9[RB]) begin
					rd_req_o <= 1'b1;
					cmd_q <= cmd9;
				end
			end
		end
	end

	// see R18
	assign data_access_o = cmd_q[DB];
	assign read_access_o = cmd_q[RB];
	assign block_select_o = cmd_q[`OWSL_CMD_BLK_BIT];
	assign addr_o = cmd_q[`OWSL_ADDR_W-1:0];
	assign busy_o = state != owsl_pkg::OWSL_S_IDLE;

	// ----------------------------------------------------------------
	// read answer transmitter
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cyc <= '0;
			tbit <= 5'h00;
			txd <= '0;
		end else if (state == owsl_pkg::OWSL_S_TAKE ||
			state == owsl_pkg::OWSL_S_SEND) begin
			if (cyc == period - CW'(1)) begin
				cyc <= '0;
				if (state == owsl_pkg::OWSL_S_TAKE) begin
					txd <= {^rd_data_i[15:8], rd_data_i[15:8],
						^rd_data_i[7:0], rd_data_i[7:0], 1'b0}; // see R3, R17
					tbit <= 5'h00;
				end else begin
					txd <= {txd[`OWSL_TX_BITS-2:0], 1'b0}; // see R2
					tbit <= tbit + 5'h01;
				end
			end else begin
				cyc <= cyc + CW'(1);
			end
		end else begin
			cyc <= '0;
			tbit <= 5'h00;
		end
	end

	always_comb begin
		next_oe = 1'b0;
		next_out = 1'b0;
		if (state == owsl_pkg::OWSL_S_TAKE) begin
			next_oe = 1'b1; // see R6
		end else if (state == owsl_pkg::OWSL_S_SEND) begin
			next_oe = 1'b1;
			if (cyc < q1) begin
				next_out = 1'b1; // see R11
			end else if (cyc < q3) begin
				next_out = txd[`OWSL_TX_BITS-1]; // see R12
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			link.s_oe <= 1'b0;
			link.s_out <= 1'b0;
		end else begin
			link.s_oe <= next_oe;
			link.s_out <= next_out;
		end
	end
endmodule : owsl_slave
`default_nettype wire

// *** design/owsl_master.sv ***
// master end of the single-wire programming link
`default_nettype none
`include "owsl_regs.svh"
module owsl_master #(
	parameter int BIT_CYC = `OWSL_MBIT_CYC,
	parameter int FILT_LEN = `OWSL_FILT_CYC,
	parameter int TMO_CYC = `OWSL_TMO_CYC
) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	owsl_if.master link,
	input wire logic start_i,
	input wire logic [7:0] cmd_i,
	input wire logic [15:0] wdata_i,
	output logic busy_o,
	output logic done_o,
	output logic rd_err_o,
	output logic [15:0] rdata_o
);
	localparam int CW = `OWSL_CNT_W;
	localparam logic [CW-1:0] BIT_N = CW'(BIT_CYC);
	localparam logic [CW-1:0] Q1 = CW'(BIT_CYC / 4);
	localparam logic [CW-1:0] Q3 = CW'(3 * (BIT_CYC / 4));

	owsl_pkg::owsl_mstate_type state;
	logic filt;
	logic filt_d;
	logic rise;
	logic fall;
	logic seen;
	logic is_rd;
	logic bitv;
	logic [CW-1:0] cyc;
	logic [CW-1:0] high_cnt;
	logic [4:0] idx;
	logic [4:0] last;
	logic [4:0] nrx;
	logic [`OWSL_MTX_BITS-1:0] txd;
	logic [`OWSL_RX_BITS-1:0] rx;
	logic next_out;
	logic next_oe;

	owsl_deglitch #(.FILT_LEN(FILT_LEN)) u_flt (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.pin_i(link.line),
		.level_o(filt)
	);

	assign rise = filt & ~filt_d;
	assign fall = ~filt & filt_d;
	assign bitv = high_cnt > (BIT_N >> 1); // see R14
	assign busy_o = state != owsl_pkg::OWSL_M_IDLE;

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= owsl_pkg::OWSL_M_IDLE;
			cyc <= '0;
			idx <= 5'h00;
			last <= 5'h00;
			is_rd <= 1'b0;
			txd <= '0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			cyc <= cyc + CW'(1);
			case (state)
				owsl_pkg::OWSL_M_IDLE: begin
					cyc <= '0;
					idx <= 5'h00;
					if (start_i) begin
						state <= owsl_pkg::OWSL_M_SEND; // see R1, R15
						is_rd <= cmd_i[7] & cmd_i[6];
						last <= (cmd_i[7] & ~cmd_i[6]) ?
							5'(`OWSL_MTX_BITS - 1) : 5'(`OWSL_CMD_BITS); // see R4, R9
						txd <= {1'b1, ^cmd_i, cmd_i, ^wdata_i[15:8],
							wdata_i[15:8], ^wdata_i[7:0], wdata_i[7:0]};
					end
				end
				owsl_pkg::OWSL_M_SEND: begin
					if (is_rd && idx == last && cyc == Q3) begin
						state <= owsl_pkg::OWSL_M_LISTEN; // see R5
						cyc <= '0;
					end else if (cyc == BIT_N - CW'(1)) begin
						cyc <= '0;
						idx <= idx + 5'h01;
						txd <= {txd[`OWSL_MTX_BITS-2:0], 1'b0};
						if (idx == last) begin
							state <= owsl_pkg::OWSL_M_STOP;
						end
					end
				end
				owsl_pkg::OWSL_M_LISTEN: begin
					if (rise || fall) begin
						cyc <= '0;
					end
					if (fall && seen && nrx == 5'(`OWSL_RX_BITS)) begin
						state <= owsl_pkg::OWSL_M_TAKE; // see R8
						cyc <= '0;
					end else if (cyc > CW'(TMO_CYC)) begin
						state <= owsl_pkg::OWSL_M_STOP;
						cyc <= '0;
					end
				end
				owsl_pkg::OWSL_M_TAKE: begin
					if (cyc == BIT_N - CW'(1)) begin
						state <= owsl_pkg::OWSL_M_STOP;
						cyc <= '0;
					end
				end
				owsl_pkg::OWSL_M_STOP: begin
					if (cyc == CW'(`OWSL_STOP_PER * BIT_CYC - 1)) begin
						state <= owsl_pkg::OWSL_M_IDLE;
						done_o <= 1'b1;
					end
				end
				default: begin
					state <= owsl_pkg::OWSL_M_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read word receiver
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			filt_d <= 1'b0;
			seen <= 1'b0;
			high_cnt <= '0;
			nrx <= 5'h00;
			rx <= '0;
			rdata_o <= 16'h0000;
			rd_err_o <= 1'b0;
		end else begin
			filt_d <= filt;
			if (state != owsl_pkg::OWSL_M_LISTEN) begin
				seen <= 1'b0;
				nrx <= 5'h00;
				if (state == owsl_pkg::OWSL_M_IDLE && start_i) begin
					rd_err_o <= 1'b0;
				end
			end else if (rise) begin
				seen <= 1'b1;
				high_cnt <= CW'(1);
			end else if (filt) begin
				high_cnt <= high_cnt + CW'(1);
			end else if (fall && seen) begin
				if (nrx == 5'(`OWSL_RX_BITS)) begin
					rdata_o <= {rx[16:9], rx[7:0]}; // see R2, R17
					rd_err_o <= rx[17] != ^rx[16:9] || rx[8] != ^rx[7:0];
				end else begin
					rx <= {rx[`OWSL_RX_BITS-2:0], bitv};
					nrx <= nrx + 5'h01;
				end
			end else if (cyc > CW'(TMO_CYC)) begin
				rd_err_o <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// line driver
	// ----------------------------------------------------------------
	always_comb begin
		next_oe = 1'b1;
		next_out = 1'b0;
		case (state)
			owsl_pkg::OWSL_M_SEND: begin
				if (cyc < Q1) begin
					next_out = 1'b1; // see R11
				end else if (cyc < Q3) begin
					next_out = txd[`OWSL_MTX_BITS-1]; // see R12
				end
			end
			owsl_pkg::OWSL_M_LISTEN: next_oe = 1'b0;
			owsl_pkg::OWSL_M_STOP: next_out = 1'b1;
			default: next_out = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			link.m_oe <= 1'b0;
			link.m_out <= 1'b0;
		end else begin
			link.m_oe <= next_oe;
			link.m_out <= next_out;
		end
	end
endmodule : owsl_master
`default_nettype wire

// *** testbench/owsl_link_monitor.sv ***
// concurrent checks on the shared single-wire link
`default_nettype none
module owsl_link_monitor (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic m_out,
	input wire logic m_oe,
	input wire logic s_out,
	input wire logic s_oe,
	input wire logic line
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	// ----------------------------------------
	// segment shapes
	// ----------------------------------------
	sequence seg_high;
		line [*8];
	endsequence
	sequence seg_low;
		!line [*8];
	endsequence
	sequence drive_low;
		!m_out [*8];
	endsequence
	// ----------------------------------------
	// wire ownership and bit shape
	// ----------------------------------------
	chk_single_driver: assert property (m_oe && s_oe |->
		!m_out && !s_out)
		else $error("both ends drive the wire, not both low");
	chk_overlap_short: assert property (m_oe && s_oe |->
		##[1:40] !(m_oe && s_oe))
		else $error("both ends drive the wire too long");
	chk_master_seg_high: assert property ($rose(line) && m_oe |-> seg_high)
		else $error("master first segment too short");
	chk_master_seg_low: assert property ($fell(line) && m_oe |-> seg_low)
		else $error("master low segment too short");
	chk_slave_seg_high: assert property ($rose(line) && s_oe |-> seg_high)
		else $error("slave first segment too short");
	chk_slave_takeover: assert property ($rose(s_oe) |-> !s_out && !$past(line))
		else $error("slave takeover not low after fall");
	chk_master_handover: assert property ($fell(m_oe) |-> $past(m_out) == 1'b0)
		else $error("master released while high");
	chk_slave_handover: assert property ($fell(s_oe) |-> $past(s_out) == 1'b0)
		else $error("slave released while high");
	chk_master_takeback: assert property ($fell(s_oe) |-> ##[1:60] m_oe)
		else $error("master did not take the wire back");
	chk_takeback_low: assert property ($rose(m_oe) |-> drive_low)
		else $error("master takeover not held low");
endmodule : owsl_link_monitor
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench joining master and slave ends
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, rst, start, mbusy, done, rerr;
	logic exec, rreq, perr, sbusy, dacc, racc, blk;
	logic [4:0] addr;
	logic [7:0] cmd;
	logic [15:0] wdata, rdata, rd_data, swdata;
	int fails, checks, n_exec, n_rreq, n_perr;
	owsl_if link ();
	owsl_master #(.BIT_CYC(40), .TMO_CYC(200)) owsl_master_inst (
		.core_clk_i(core_clk), .sys_rst_i(rst), .link(link),
		.start_i(start), .cmd_i(cmd), .wdata_i(wdata), .busy_o(mbusy),
		.done_o(done), .rd_err_o(rerr), .rdata_o(rdata));
	owsl_slave #(.TMO_CYC(200)) owsl_slave_inst (
		.core_clk_i(core_clk), .sys_rst_i(rst), .link(link),
		.rd_data_i(rd_data), .exec_o(exec), .rd_req_o(rreq),
		.perr_o(perr), .busy_o(sbusy), .data_access_o(dacc),
		.read_access_o(racc), .block_select_o(blk), .addr_o(addr),
		.wdata_o(swdata));
	owsl_link_monitor owsl_link_monitor_inst (
		.core_clk_i(core_clk), .sys_rst_i(rst), .m_out(link.m_out),
		.m_oe(link.m_oe), .s_out(link.s_out), .s_oe(link.s_oe),
		.line(link.line));
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (exec === 1'b1) n_exec++;
		if (rreq === 1'b1) n_rreq++;
		if (perr === 1'b1) n_perr++;
	end
	// ----------------------------------------
	// compare and access tasks
	// ----------------------------------------
	task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_val
	task automatic cmp_level(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_level
	task automatic xfer(input logic [7:0] c, input logic [15:0] w);
		int t;
		t = 0;
		@(posedge core_clk);
		start <= 1'b1;
		cmd <= c;
		wdata <= w;
		@(posedge core_clk);
		start <= 1'b0;
		while (done !== 1'b1 && t < 4000) begin
			@(posedge core_clk);
			t++;
		end
		cmp_level(t < 4000, 1'b1);
	endtask : xfer
	// sample each wire bit in the middle of its four segments
	task automatic grab(input int n, input logic [27:0] f);
		int i, t;
		for (i = 27; i > 27 - n; i--) begin
			t = 0;
			while (link.line !== 1'b1 && t < 200) begin
				@(posedge core_clk);
				t++;
			end
			repeat (5) @(posedge core_clk);
			cmp_level(link.line, 1'b1);
			repeat (10) @(posedge core_clk);
			cmp_level(link.line, f[i]);
			repeat (10) @(posedge core_clk);
			cmp_level(link.line, f[i]);
			repeat (10) @(posedge core_clk);
			cmp_level(link.line, 1'b0);
		end
	endtask : grab
	function automatic logic [27:0] frame(input logic [7:0] c,
			input logic [15:0] w);
		return {1'b1, ^c, c, ^w[15:8], w[15:8], ^w[7:0], w[7:0]};
	endfunction : frame
	task automatic check_fields(input logic [7:0] c);
		repeat (2) @(posedge core_clk);
		cmp_val({8'h00, dacc, racc, blk, addr}, {8'h00, c});
		cmp_level(sbusy, 1'b0);
	endtask : check_fields
	task automatic close_out;
		$display("counts: %0d checks, %0d fails", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		start = 1'b0;
		cmd = 8'h00;
		wdata = 16'h0000;
		rd_data = 16'h9a6b;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		repeat (8) @(posedge core_clk);
		cmp_level(sbusy, 1'b0);
		fork
			xfer(8'h1a, 16'h0000);
			grab(10, frame(8'h1a, 16'h0000));
		join
		check_fields(8'h1a);
		cmp_val(16'(n_exec), 16'h0001);
		$display("test action done");
		fork
			xfer(8'hb5, 16'hc7f0);
			grab(28, frame(8'hb5, 16'hc7f0));
		join
		xfer(8'hb5, 16'h0f3c);
		check_fields(8'hb5);
		cmp_val(swdata, 16'h0f3c);
		cmp_val(16'(n_exec), 16'h0003);
		$display("test write done");
		xfer(8'hc9, 16'h0000);
		check_fields(8'hc9);
		cmp_val(rdata, 16'h9a6b);
		cmp_level(rerr, 1'b0);
		cmp_val(16'(n_rreq), 16'h0001);
		cmp_val(16'(n_exec), 16'h0003);
		cmp_val(16'(n_perr), 16'h0000);
		$display("test read done");
		close_out();
	end
	initial begin
		#1000000;
		fails++;
		close_out();
	end
endmodule : tb_top
`default_nettype wire
